// ### afe_output_pkg.sv
/*
 * Constants for the output format, line sync pulse, tri-state and
 * power-down register bank of the video digitizer output stage.
 * Assumes one 10 MHz clock and a plain register port with 8-bit data.
 */
package afe_output_pkg;

	// Register offsets
	localparam logic [7:0] LOCK_EDGE_OFFSET = 8'h23;
	localparam logic [7:0] COLOR_FORMAT_OFFSET = 8'h28;
	localparam logic [7:0] OUTPUT_PIN_FORMAT_OFFSET = 8'h29;
	localparam logic [7:0] LINE_SYNC_OUT_WIDTH_OFFSET = 8'h2a;
	localparam logic [7:0] OUTPUT_TRISTATE_CONTROL_OFFSET = 8'h2b;
	localparam logic [7:0] POWER_DOWN_CONTROL_OFFSET = 8'h2c;
	localparam logic [7:0] BLOCK_STATUS_OFFSET = 8'h3f;

	// Reset values
	localparam logic [7:0] OUTPUT_PIN_FORMAT_RESET = 8'h00;
	localparam logic [7:0] LINE_SYNC_OUT_WIDTH_RESET = 8'h10;
	localparam logic [7:0] OUTPUT_TRISTATE_CONTROL_RESET = 8'hff;
	localparam logic [7:0] POWER_DOWN_CONTROL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Output pin format fields
	localparam int FMT_DATA_RISING = 0;
	localparam int FMT_FIELD_INVERT = 1;
	localparam int FMT_BLANK_PROTECTED = 2;
	localparam int FMT_SYNC_ACTIVE_LOW = 3;
	localparam int FMT_SYNC_TRAIL_LOCK = 4;
	localparam int FMT_XTAL_HALF = 5;
	localparam int FMT_XTAL_ENABLE = 6;

	// Fields of the borrowed configuration registers
	localparam int LOCK_EDGE_LEADING_BIT = 0;
	localparam int COLOR_CONVERT_BIT = 6;

	// Tri-state groups
	localparam int TRI_RED = 0;
	localparam int TRI_GREEN = 1;
	localparam int TRI_BLUE = 2;
	localparam int TRI_SYNC = 3;
	localparam int TRI_PIXEL_CLOCK = 4;
	localparam int TRI_PIXEL_CLOCK_INV = 5;
	localparam int TRI_DATA_VALID = 6;
	localparam int TRI_FIELD = 7;

	// Power fields
	localparam int PWR_ADC_MSB = 2;
	localparam int PWR_PLL = 3;

	// Status fields
	localparam int STAT_BLANKING = 0;
	localparam int STAT_PULSE = 1;
	localparam int STAT_TRACKING = 2;

	// Data channels; green carries luma in YUV
	localparam int CHANNELS = 3;
	localparam int CH_GREEN = 1;
	localparam logic [7:0] BLANK_ZERO = 8'h00;
	localparam logic [7:0] BLANK_MID = 8'h80;

	// Pixel counter
	localparam int COUNT_WIDTH = 16;
	localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 16'hffff;
	localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 16'h0001;

	// Line sync generator states
	typedef enum logic [1:0] {
		SYNC_WAIT = 2'b01,
		SYNC_TRACK = 2'b10
	} sync_state_e;

endpackage

// ### afe_output_power_control.sv
/*
 * Output stage of the video digitizer: register bank, pixel clock and
 * data launch, copy-protection blanking, line sync pulse generator,
 * crystal clock output, tri-state enables and power-down controls.
 * Assumes all inputs are synchronous to clk and the register master
 * issues one-cycle strobes; read data follows one cycle later.
 */
`timescale 1ns/10ps
module afe_output_power_control import afe_output_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] red_in,
	input wire logic [7:0] green_in,
	input wire logic [7:0] blue_in,
	input wire logic data_valid_in,
	input wire logic field_even_in,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic copy_protect_detected,
	output logic [7:0] red_out,
	output logic red_oe,
	output logic [7:0] green_out,
	output logic green_oe,
	output logic [7:0] blue_out,
	output logic blue_oe,
	output logic line_sync_pulse_out,
	output logic raw_line_sync_out,
	output logic frame_sync_out,
	output logic sync_oe,
	output logic pixel_clock_out,
	output logic pixel_clock_oe,
	output logic pixel_clock_out_inverted,
	output logic pixel_clock_inverted_oe,
	output logic data_valid_out,
	output logic data_valid_oe,
	output logic field_out,
	output logic field_oe,
	output logic crystal_clock_out,
	output logic [2:0] adc_power_down,
	output logic pll_power_down
);

	// Blanking code for one channel
	function automatic logic [7:0] blank_code(input int ch, input logic yuv);
		logic [7:0] code;
		code = BLANK_ZERO;
		if (yuv && ch != CH_GREEN) begin
			code = BLANK_MID;
		end
		return code;
	endfunction

	logic [7:0] format_reg, format_next;
	logic [7:0] width_reg, width_next;
	logic [7:0] tristate_reg, tristate_next;
	logic [7:0] power_reg, power_next;
	logic lock_leading_reg, lock_leading_next;
	logic color_convert_reg, color_convert_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] oe_reg, oe_next;
	logic pclk_reg, pclk_next;
	logic pclk_inv_reg, pclk_inv_next;
	logic pixel_tick;
	logic blanking;
	logic [7:0] chan_in [CHANNELS];
	logic [7:0] chan_reg [CHANNELS];
	logic [7:0] chan_next [CHANNELS];
	logic valid_reg, valid_next;
	logic field_reg, field_next;
	logic raw_sync_reg, raw_sync_next;
	logic frame_sync_reg, frame_sync_next;
	logic xdiv_reg, xdiv_next;
	logic xclk_reg, xclk_next;
	sync_state_e state_reg, state_next;
	logic sync_prev_reg, sync_prev_next;
	logic [COUNT_WIDTH-1:0] count_reg, count_next;
	logic [COUNT_WIDTH-1:0] line_len_reg, line_len_next;
	logic pulse_reg, pulse_next;
	logic active_reg, active_next;
	logic lock_edge;
	logic [COUNT_WIDTH:0] end_sum;

	// Register writes and registered read data
	always_comb begin
		format_next = format_reg;
		width_next = width_reg;
		tristate_next = tristate_reg;
		power_next = power_reg;
		lock_leading_next = lock_leading_reg;
		color_convert_next = color_convert_reg;
		rdata_next = READ_ZERO;
		if (reg_wr) begin
			case (reg_addr)
				LOCK_EDGE_OFFSET: lock_leading_next = reg_wdata[LOCK_EDGE_LEADING_BIT];
				COLOR_FORMAT_OFFSET: color_convert_next = reg_wdata[COLOR_CONVERT_BIT];
				OUTPUT_PIN_FORMAT_OFFSET: format_next = reg_wdata;
				LINE_SYNC_OUT_WIDTH_OFFSET: width_next = reg_wdata;
				OUTPUT_TRISTATE_CONTROL_OFFSET: tristate_next = reg_wdata;
				POWER_DOWN_CONTROL_OFFSET: power_next = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				LOCK_EDGE_OFFSET: rdata_next[LOCK_EDGE_LEADING_BIT] = lock_leading_reg;
				COLOR_FORMAT_OFFSET: rdata_next[COLOR_CONVERT_BIT] = color_convert_reg;
				OUTPUT_PIN_FORMAT_OFFSET: rdata_next = format_reg;
				LINE_SYNC_OUT_WIDTH_OFFSET: rdata_next = width_reg;
				OUTPUT_TRISTATE_CONTROL_OFFSET: rdata_next = tristate_reg;
				POWER_DOWN_CONTROL_OFFSET: rdata_next = power_reg;
				BLOCK_STATUS_OFFSET: begin
					rdata_next[STAT_BLANKING] = blanking;
					rdata_next[STAT_PULSE] = active_reg;
					rdata_next[STAT_TRACKING] = (state_reg == SYNC_TRACK);
				end
				default: rdata_next = READ_ZERO;
			endcase
		end
		oe_next = ~tristate_next;
	end

	// Register storage
	always_ff @(posedge clk) begin
		if (rst) begin
			format_reg <= OUTPUT_PIN_FORMAT_RESET;
			width_reg <= LINE_SYNC_OUT_WIDTH_RESET;
			tristate_reg <= OUTPUT_TRISTATE_CONTROL_RESET;
			oe_reg <= ~OUTPUT_TRISTATE_CONTROL_RESET;
			power_reg <= POWER_DOWN_CONTROL_RESET;
			lock_leading_reg <= 1'b0;
			color_convert_reg <= 1'b0;
			rdata_reg <= READ_ZERO;
		end else begin
			format_reg <= format_next;
			width_reg <= width_next;
			tristate_reg <= tristate_next;
			oe_reg <= oe_next;
			power_reg <= power_next;
			lock_leading_reg <= lock_leading_next;
			color_convert_reg <= color_convert_next;
			rdata_reg <= rdata_next;
		end
	end

	// Pixel clock at half of clk; data launches on the chosen edge
	always_comb begin
		pclk_next = ~pclk_reg;
		pclk_inv_next = pclk_reg;
		pixel_tick = (pclk_next == format_reg[FMT_DATA_RISING]);
		blanking = format_reg[FMT_BLANK_PROTECTED] && copy_protect_detected;
		valid_next = pixel_tick ? data_valid_in : valid_reg;
		field_next = pixel_tick ? (field_even_in ^ format_reg[FMT_FIELD_INVERT]) : field_reg;
		raw_sync_next = pixel_tick ? line_sync_in : raw_sync_reg;
		frame_sync_next = pixel_tick ? frame_sync_in : frame_sync_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pclk_reg <= 1'b0;
			pclk_inv_reg <= 1'b1;
			valid_reg <= 1'b0;
			field_reg <= 1'b0;
			raw_sync_reg <= 1'b0;
			frame_sync_reg <= 1'b0;
		end else begin
			pclk_reg <= pclk_next;
			pclk_inv_reg <= pclk_inv_next;
			valid_reg <= valid_next;
			field_reg <= field_next;
			raw_sync_reg <= raw_sync_next;
			frame_sync_reg <= frame_sync_next;
		end
	end

	assign chan_in[0] = red_in;
	assign chan_in[1] = green_in;
	assign chan_in[2] = blue_in;

	// Per-channel data launch with blanking
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		always_comb begin
			chan_next[ch] = chan_reg[ch];
			if (pixel_tick) begin
				chan_next[ch] = blanking ? blank_code(ch, color_convert_reg) : chan_in[ch];
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				chan_reg[ch] <= BLANK_ZERO;
			end else begin
				chan_reg[ch] <= chan_next[ch];
			end
		end
	end

	// Crystal clock output, gated and optionally halved
	always_comb begin
		xdiv_next = ~xdiv_reg;
		xclk_next = xclk_reg;
		if (!format_reg[FMT_XTAL_ENABLE]) begin
			xclk_next = 1'b0;
		end else if (!format_reg[FMT_XTAL_HALF] || xdiv_reg) begin
			xclk_next = ~xclk_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			xdiv_reg <= 1'b0;
			xclk_reg <= 1'b0;
		end else begin
			xdiv_reg <= xdiv_next;
			xclk_reg <= xclk_next;
		end
	end

	// Line sync pulse: pixel counter restarted on each lock edge
	always_comb begin
		sync_prev_next = line_sync_in;
		lock_edge = lock_leading_reg ? (line_sync_in && !sync_prev_reg) : (!line_sync_in && sync_prev_reg);
		state_next = state_reg;
		count_next = count_reg;
		line_len_next = line_len_reg;
		if (lock_edge) begin
			state_next = SYNC_TRACK;
			count_next = '0;
			if (state_reg == SYNC_TRACK) begin
				line_len_next = count_reg;
			end
		end else if (pixel_tick && count_reg != COUNT_MAX) begin
			count_next = count_reg + COUNT_ONE;
		end
		end_sum = {1'b0, count_next} + (COUNT_WIDTH+1)'(width_reg);
		case (state_next)
			SYNC_WAIT: active_next = 1'b0;
			SYNC_TRACK: begin
				if (!format_reg[FMT_SYNC_TRAIL_LOCK]) begin
					// Opens only at a lock edge, so a width write mid-line cannot start a pulse
					active_next = (lock_edge || active_reg)
						&& (count_next < COUNT_WIDTH'(width_reg));
				end else begin
					active_next = (width_reg != '0) && (line_len_next != '0)
						&& (end_sum >= {1'b0, line_len_next});
				end
			end
			default: active_next = 1'b0;
		endcase
		pulse_next = active_next ^ format_reg[FMT_SYNC_ACTIVE_LOW];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= SYNC_WAIT;
			sync_prev_reg <= 1'b0;
			count_reg <= '0;
			line_len_reg <= '0;
			active_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sync_prev_reg <= sync_prev_next;
			count_reg <= count_next;
			line_len_reg <= line_len_next;
			active_reg <= active_next;
			pulse_reg <= pulse_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_reg;
	assign red_out = chan_reg[0];
	assign green_out = chan_reg[1];
	assign blue_out = chan_reg[2];
	assign red_oe = oe_reg[TRI_RED];
	assign green_oe = oe_reg[TRI_GREEN];
	assign blue_oe = oe_reg[TRI_BLUE];
	assign sync_oe = oe_reg[TRI_SYNC];
	assign pixel_clock_oe = oe_reg[TRI_PIXEL_CLOCK];
	assign pixel_clock_inverted_oe = oe_reg[TRI_PIXEL_CLOCK_INV];
	assign data_valid_oe = oe_reg[TRI_DATA_VALID];
	assign field_oe = oe_reg[TRI_FIELD];
	assign line_sync_pulse_out = pulse_reg;
	assign raw_line_sync_out = raw_sync_reg;
	assign frame_sync_out = frame_sync_reg;
	assign pixel_clock_out = pclk_reg;
	assign pixel_clock_out_inverted = pclk_inv_reg;
	assign data_valid_out = valid_reg;
	assign field_out = field_reg;
	assign crystal_clock_out = xclk_reg;
	assign adc_power_down = power_reg[PWR_ADC_MSB:0];
	assign pll_power_down = power_reg[PWR_PLL];

endmodule

// ### afe_output_checker.sv
/*
 Assertions on the output stage ports: register mirror, enables,
 power, pixel launch, blanking, crystal clock and line sync pulse.
 Assumes it is bound to the output stage top and sees its ports only.
*/
`timescale 1ns/10ps
module afe_output_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic field_even_in,
	input wire logic line_sync_in,
	input wire logic copy_protect_detected,
	input wire logic data_valid_in,
	input wire logic frame_sync_in,
	input wire logic [7:0] red_out,
	input wire logic [7:0] green_out,
	input wire logic [7:0] blue_out,
	input wire logic red_oe,
	input wire logic green_oe,
	input wire logic blue_oe,
	input wire logic sync_oe,
	input wire logic pixel_clock_oe,
	input wire logic pixel_clock_inverted_oe,
	input wire logic data_valid_oe,
	input wire logic field_oe,
	input wire logic line_sync_pulse_out,
	input wire logic pixel_clock_out,
	input wire logic field_out,
	input wire logic raw_line_sync_out,
	input wire logic frame_sync_out,
	input wire logic data_valid_out,
	input wire logic pixel_clock_out_inverted,
	input wire logic crystal_clock_out,
	input wire logic [2:0] adc_power_down,
	input wire logic pll_power_down
);
	logic [7:0] fmt, fmt_q, wid, tsc;
	logic [3:0] pwr;
	logic yuv, lk, act_q;
	logic [9:0] cnt;
	wire logic [7:0] oes = {field_oe, data_valid_oe, pixel_clock_inverted_oe, pixel_clock_oe,
		sync_oe, blue_oe, green_oe, red_oe};
	wire logic act = line_sync_pulse_out ^ fmt_q[3];
	wire logic lch = pixel_clock_out == fmt[0];
	wire logic st = fmt == fmt_q;
	// Mirror of register writes and pulse length counter
	always_ff @(posedge clk) begin
		fmt_q <= fmt;
		act_q <= act;
		cnt <= act ? cnt + 10'h001 : 10'h000;
		if (rst) begin
			fmt <= 8'h00;
			wid <= 8'h10;
			tsc <= 8'hff;
			pwr <= 4'h0;
			yuv <= 1'b0;
			lk <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				8'h23: lk <= reg_wdata[0];
				8'h28: yuv <= reg_wdata[6];
				8'h29: fmt <= reg_wdata;
				8'h2a: wid <= reg_wdata;
				8'h2b: tsc <= reg_wdata;
				8'h2c: pwr <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	tsc_readback_a: assert property (reg_rd && reg_addr == 8'h2b |=> reg_rdata == tsc)
		else $error("tri-state readback wrong");
	oe_map_a: assert property (oes == (tsc ^ 8'hff)) else $error("enable map wrong");
	power_map_a: assert property ({pll_power_down, adc_power_down} == pwr)
		else $error("power-down wrong");
	data_edge_a: assert property ($changed(red_out) && st |-> lch) else $error("data edge wrong");
	field_pol_a: assert property (lch && st |-> field_out == ($past(field_even_in) ^ fmt[1]))
		else $error("field level wrong");
	blank_out_a: assert property (lch && st && fmt[2] && $past(copy_protect_detected)
		|-> {red_out, green_out, blue_out} == (yuv ? 24'h800080 : 24'h000000)) else $error("blanking wrong");
	xtal_low_a: assert property (st && !fmt[6] |-> !crystal_clock_out) else $error("crystal not low");
	xtal_fast_a: assert property (st && fmt[6] && !fmt[5] |-> $changed(crystal_clock_out))
		else $error("crystal not full rate");
	xtal_half_a: assert property (st && fmt[6] && fmt[5] ##1 st && fmt[6] && fmt[5]
		|-> crystal_clock_out != $past(crystal_clock_out, 2)) else $error("crystal not half rate");
	pclk_pair_a: assert property (pixel_clock_out_inverted != pixel_clock_out)
		else $error("inverted pixel clock wrong");
	sync_copy_a: assert property (lch && st && !$past(rst)
		|-> raw_line_sync_out == $past(line_sync_in) && frame_sync_out == $past(frame_sync_in)
		&& data_valid_out == $past(data_valid_in)) else $error("sync copy wrong");
	pulse_start_a: assert property (!fmt[4] && wid != 8'h00
		&& (lk ? $rose(line_sync_in) : $fell(line_sync_in)) |-> ##[1:3] act) else $error("pulse late");
	pulse_width_a: assert property (act_q && !act && !fmt_q[4] && wid != 8'h00
		|-> cnt == {1'b0, wid, 1'b0} || cnt + 10'h001 == {1'b0, wid, 1'b0}) else $error("pulse width wrong");
endmodule

bind afe_output_power_control afe_output_checker chk_i (.*);

// ### video_sink.sv
/*
 Downstream video processor: captures pixels on the rising pixel clock.
 Assumes default polarity, where data changes on the falling edge.
*/
`timescale 1ns/10ps
module video_sink (
	input wire logic pclk,
	input wire logic oe,
	input wire logic [23:0] pix,
	output logic [23:0] last
);
	// Capture mid-pixel while the data pins are driven
	always_ff @(posedge pclk) begin
		if (oe) begin
			last <= pix;
		end
	end
endmodule

// ### tb_top.sv
/*
 Testbench for the output stage: registers, enables, power, blanking,
 field, crystal clock and line sync pulse.
 Assumes the package, design, checker and sink are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, red_in = 8'h5a, green_in = 8'ha5, blue_in = 8'h3c;
	logic data_valid_in = 1'b1, field_even_in = 1'b0, line_sync_in = 1'b0, frame_sync_in = 1'b0;
	logic copy_protect_detected = 1'b0;
	wire logic [7:0] reg_rdata, red_out, green_out, blue_out;
	wire logic [2:0] adc_power_down;
	wire logic red_oe, green_oe, blue_oe, sync_oe, pixel_clock_oe, pixel_clock_inverted_oe, data_valid_oe, field_oe;
	wire logic line_sync_pulse_out, raw_line_sync_out, frame_sync_out, pixel_clock_out, pixel_clock_out_inverted;
	wire logic data_valid_out, field_out, crystal_clock_out, pll_power_down;
	wire logic [7:0] oes = {field_oe, data_valid_oe, pixel_clock_inverted_oe, pixel_clock_oe,
		sync_oe, blue_oe, green_oe, red_oe};
	wire logic [23:0] seen;
	int n_fail = 0, checked = 0;
	afe_output_power_control DUT (.*);
	video_sink sink (.pclk(pixel_clock_out), .oe(&oes[2:0]), .pix({red_out, green_out, blue_out}), .last(seen));
	// Free-running 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, reg_rdata);
	endtask
	// Count crystal output toggles over 40 clocks
	task automatic xt(logic [7:0] f, int e);
		int n;
		logic p;
		wr(8'h29, f);
		cyc(4);
		n = 0;
		repeat (40) begin
			p = crystal_clock_out;
			cyc(1);
			n += (p !== crystal_clock_out);
		end
		chk("xtal", e, n);
	endtask
	// One lock edge, then measure start delay and pulse length
	task automatic hs(logic [7:0] w, logic [7:0] f, logic l);
		int d, n;
		wr(8'h2a, w);
		wr(8'h29, f);
		wr(8'h23, {7'h00, l});
		@(posedge clk);
		line_sync_in <= ~l;
		cyc(8);
		chk("hs_idle", f[3], line_sync_pulse_out);
		@(posedge clk);
		line_sync_in <= l;
		d = 0;
		n = 0;
		while (d < 6 && line_sync_pulse_out == f[3]) begin
			cyc(1);
			d++;
		end
		while (line_sync_pulse_out != f[3] && n < 600) begin
			cyc(1);
			n++;
		end
		chk("hs_start", w != 8'h00, d < 6);
		chk("hs_width", w, (n + 1) / 2);
		@(posedge clk);
		line_sync_in <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("ERROR watchdog expected done seen hang");
		wrap_up();
	end
	// Main sequence
	initial begin
		logic [7:0] m;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(8'h29, 8'h00);
		rd(8'h2a, 8'h10);
		rd(8'h2b, 8'hff);
		rd(8'h2c, 8'h00);
		rd(8'h3f, 8'h00);
		rd(8'h50, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			wr(8'h2b, m);
			cyc(1);
			chk("oe", m ^ 8'hff, oes);
		end
		wr(8'h2c, 8'h0f);
		cyc(2);
		chk("pwr", 4'hf, {pll_power_down, adc_power_down});
		wr(8'h2c, 8'h05);
		cyc(2);
		chk("pwr", 4'h5, {pll_power_down, adc_power_down});
		wr(8'h2b, 8'h00);
		$display("test enables done");
		cyc(6);
		chk("pix", 24'h5aa53c, seen);
		wr(8'h29, 8'h04);
		@(posedge clk);
		copy_protect_detected <= 1'b1;
		cyc(6);
		chk("blank", 24'h000000, seen);
		@(posedge clk);
		copy_protect_detected <= 1'b0;
		wr(8'h28, 8'h40);
		cyc(6);
		chk("pix", 24'h5aa53c, seen);
		@(posedge clk);
		copy_protect_detected <= 1'b1;
		cyc(6);
		chk("blank", 24'h800080, seen);
		rd(8'h28, 8'h40);
		@(posedge clk);
		copy_protect_detected <= 1'b0;
		$display("test blanking done");
		@(posedge clk);
		field_even_in <= 1'b1;
		cyc(4);
		chk("field", 1'b1, field_out);
		wr(8'h29, 8'h03);
		@(posedge clk);
		red_in <= 8'h11;
		cyc(4);
		chk("field", 1'b0, field_out);
		$display("test field done");
		xt(8'h40, 40);
		xt(8'h60, 20);
		xt(8'h00, 0);
		chk("xtal_low", 1'b0, crystal_clock_out);
		$display("test crystal done");
		hs(8'h10, 8'h00, 1'b0);
		hs(8'h01, 8'h00, 1'b0);
		hs(8'hff, 8'h00, 1'b0);
		hs(8'h00, 8'h00, 1'b0);
		hs(8'h10, 8'h08, 1'b1);
		// Trailing lock: regular lines, pulse checked to end at the fourth falling lock edge
		wr(8'h2a, 8'h04);
		wr(8'h29, 8'h10);
		wr(8'h23, 8'h00);
		for (int i = 0; i < 4; i++) begin
			repeat (20) @(posedge clk);
			line_sync_in <= 1'b1;
			repeat (17) @(posedge clk);
			cyc(1);
			if (i == 3) chk("hs_trail_on", 1'b1, line_sync_pulse_out);
			@(posedge clk);
			line_sync_in <= 1'b0;
			cyc(3);
			if (i == 3) chk("hs_trail_off", 1'b0, line_sync_pulse_out);
		end
		$display("test line sync done");
		wrap_up();
	end
endmodule
